// File: logic/bdu_alu.sv
// combinational arithmetic for bcd fixup and both decrements
`timescale 1ns/1ns
module bdu_alu (
   bdu_alu_if.alu a
);
   // -------------------------------------------------------------
   // bcd correction selection
   // -------------------------------------------------------------
   logic       fix_lo;   // add side: low digit needs 06
   logic       fix_hi;   // add side: high digit needs 60
   logic [7:0] corr;     // number added to the byte
   logic       cout;     // carry after the fixup
   logic [7:0] da_res;   // fixed byte
   logic [7:0] dec_b;    // byte minus one
   logic [15:0] dec_w;   // word minus one

   // the d flag tells which table applies: set means a subtract came last
   always_comb begin
      fix_lo = a.flags_in[bdu_pkg::FLG_H] | (a.byte_in[3:0] > 4'h9);
      fix_hi = a.flags_in[bdu_pkg::FLG_C] | (a.byte_in > 8'h99);
      if (a.flags_in[bdu_pkg::FLG_D]) begin
         // subtract side: FA, A0 or 9A, carry kept
         corr = (a.flags_in[bdu_pkg::FLG_H] ? 8'hFA : 8'h00)
              + (a.flags_in[bdu_pkg::FLG_C] ? 8'hA0 : 8'h00);
         cout = a.flags_in[bdu_pkg::FLG_C];
      end else begin
         // add side: 06, 60 or 66, carry on high fix
         corr = {1'b0, fix_hi, fix_hi, 1'b0, 1'b0, fix_lo, fix_lo, 1'b0};
         cout = fix_hi;
      end
      // invalid bcd input simply yields whatever this sum gives
      da_res = a.byte_in + corr;
      dec_b  = a.byte_in - 8'h01;
      dec_w  = a.word_in - 16'h0001;
   end

   // -------------------------------------------------------------
   // results and flags
   // -------------------------------------------------------------
   always_comb begin
      a.flags_out = a.flags_in;  // d and h never move here
      a.res_byte  = dec_b;
      a.res_word  = dec_w;
      case (a.op)
         bdu_pkg::OP_BCD_FIXUP: begin
            a.res_byte = da_res;
            a.flags_out[bdu_pkg::FLG_C] = cout;
            a.flags_out[bdu_pkg::FLG_Z] = (da_res == 8'h00);
            a.flags_out[bdu_pkg::FLG_S] = da_res[7];
         end
         bdu_pkg::OP_MINUS_ONE_BYTE: begin
            a.flags_out[bdu_pkg::FLG_Z] = (dec_b == 8'h00);
            a.flags_out[bdu_pkg::FLG_S] = dec_b[7];
            a.flags_out[bdu_pkg::FLG_V] = (a.byte_in == 8'h80);
         end
         bdu_pkg::OP_MINUS_ONE_WORD: begin
            a.flags_out[bdu_pkg::FLG_Z] = (dec_w == 16'h0000);
            a.flags_out[bdu_pkg::FLG_S] = dec_w[15];
            a.flags_out[bdu_pkg::FLG_V] = (a.word_in == 16'h8000);
         end
         default: begin
            a.flags_out = a.flags_in;  // irq off leaves flags alone
         end
      endcase
   end
endmodule

// File: logic/bdu_top.sv
// bcd adjust, byte and word decrement, and global irq off, behind apb
//
// Notes on behaviour
// - add side fixup adds 06, 60, 66
// - subtract side adds FA, A0, 9A
// - non-bcd input gives no defined result
// - carry follows the fixup selection
// - fixup sets zero, sign; v undefined
// - byte decrement subtracts one
// - byte decrement keeps carry, d, h
// - word decrement borrows into high byte
// - word decrement flags from 16-bit result
// - irq off clears global enable bit
// - pending still latches while disabled
// - irq off keeps flags, four cycles
`timescale 1ns/1ns
module bdu_top #(
   parameter int NUM_IRQ = 8   // interrupt request lines
) (
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire logic [11:0]        paddr_i,
   input  wire logic               psel_i,
   input  wire logic               penable_i,
   input  wire logic               pwrite_i,
   input  wire logic [31:0]        pwdata_i,
   output logic      [31:0]        prdata_o,
   output logic                    pready_o,
   output logic                    pslverr_o,
   input  wire logic [NUM_IRQ-1:0] irq_req_i,
   output logic      [NUM_IRQ-1:0] irq_service_o,
   output logic                    irq_enable_o,
   output logic                    busy_o
);
   // -------------------------------------------------------------
   // state record
   // -------------------------------------------------------------
   typedef struct packed {
      bdu_pkg::bdu_state_type  state;    // sequencer state
      logic [3:0]              cnt;      // cycles left in the op
      bdu_pkg::bdu_op_type     op;       // op in progress
      logic [3:0]              addr;     // resolved destination index
      logic [7:0]              flags;    // condition flags
      logic [7:0]              sysmode;  // system_mode_reg
      logic [NUM_IRQ-1:0]      mask;     // irq_mask_reg
      logic [NUM_IRQ-1:0]      pend;     // pending bits
      logic [NUM_IRQ-1:0]      svc;      // requests open for service
      logic [NUM_IRQ-1:0]      sync1;    // first synchroniser stage
      logic [NUM_IRQ-1:0]      sync2;    // second synchroniser stage
      logic [15:0][7:0]        rf;       // operand register file
      logic [31:0]             prdata;   // read data
      logic                    pready;   // access answer
      logic                    pslverr;  // unmapped access
   } bdu_st_type;

   bdu_st_type q;      // registered state
   bdu_st_type n;      // next state
   bdu_alu_if  alu_c ();  // carrier to the arithmetic unit

   logic        acc;      // apb access phase
   logic        commit;   // access completes this edge
   logic        rf_hit;   // address falls in the operand file
   logic        mapped;   // address decodes to something
   logic [31:0] rdata;    // read mux
   logic [3:0]  ridx;     // register index from ctrl write
   logic        fin;      // op completes this edge
   logic [3:0]  even_a;   // word high byte index
   logic [3:0]  odd_a;    // word low byte index

   // -------------------------------------------------------------
   // arithmetic unit
   // -------------------------------------------------------------
   // word pair is forced to an even base; odd bases are caller misuse
   assign even_a = {q.addr[3:1], 1'b0};
   assign odd_a  = {q.addr[3:1], 1'b1};
   assign alu_c.op       = q.op;
   assign alu_c.flags_in = q.flags;
   assign alu_c.byte_in  = q.rf[q.addr];
   assign alu_c.word_in  = {q.rf[even_a], q.rf[odd_a]};

   bdu_alu u_alu (
      .a (alu_c.alu)
   );

   // -------------------------------------------------------------
   // bus decode
   // -------------------------------------------------------------
   assign acc    = psel_i & penable_i;
   assign commit = acc & q.pready;
   assign ridx   = pwdata_i[bdu_pkg::CTL_IDX +: 4];
   assign fin    = (q.state == bdu_pkg::ST_EXEC) && (q.cnt == 4'h0);
   assign rf_hit = (paddr_i[11:8] == 4'h0) && (paddr_i[7:6] == bdu_pkg::RF_SEL)
                   && (paddr_i[1:0] == 2'h0);

   // read mux, unmapped reads return zero and an error
   always_comb begin
      rdata  = 32'h0000_0000;
      mapped = 1'b1;
      if (rf_hit) begin
         rdata[7:0] = q.rf[paddr_i[5:2]];
      end else begin
         case (paddr_i)
            bdu_pkg::OFF_CTRL: begin
               rdata[1:0] = q.op;
            end
            bdu_pkg::OFF_STATUS: begin
               rdata[0]   = (q.state == bdu_pkg::ST_EXEC);
               rdata[7:4] = q.addr;
            end
            bdu_pkg::OFF_FLAGS: begin
               rdata[7:0] = q.flags;
            end
            bdu_pkg::OFF_SYSMODE: begin
               rdata[7:0] = q.sysmode;
            end
            bdu_pkg::OFF_MASK: begin
               rdata[NUM_IRQ-1:0] = q.mask;
            end
            bdu_pkg::OFF_PEND: begin
               rdata[NUM_IRQ-1:0] = q.pend;
            end
            bdu_pkg::OFF_SVC: begin
               rdata[NUM_IRQ-1:0] = q.svc;
            end
            default: begin
               mapped = 1'b0;
            end
         endcase
      end
   end

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   always_comb begin
      n = q;
      // one wait state: answer in the cycle after penable rises
      n.pready  = acc & ~q.pready;
      n.pslverr = acc & ~q.pready & ~mapped;
      if (acc & ~q.pready) begin
         n.prdata = pwrite_i ? 32'h0000_0000 : rdata;
      end
      // software writes land on the edge that sees pready high
      if (commit & pwrite_i & mapped) begin
         if (rf_hit) begin
            n.rf[paddr_i[5:2]] = pwdata_i[7:0];
         end else begin
            case (paddr_i)
               bdu_pkg::OFF_CTRL: begin
                  // a start while busy is dropped
                  if (q.state == bdu_pkg::ST_IDLE) begin
                     n.op    = bdu_pkg::bdu_op_type'(pwdata_i[1:0]);
                     n.addr  = pwdata_i[bdu_pkg::CTL_IND] ? q.rf[ridx][3:0] : ridx;
                     n.state = bdu_pkg::ST_EXEC;
                     case (bdu_pkg::bdu_op_type'(pwdata_i[1:0]))
                        bdu_pkg::OP_MINUS_ONE_WORD: n.cnt = bdu_pkg::CYC_WORD - 4'h1;
                        bdu_pkg::OP_GLOBAL_IRQ_OFF: n.cnt = bdu_pkg::CYC_IRQOFF - 4'h1;
                        default:                    n.cnt = bdu_pkg::CYC_BYTE - 4'h1;
                     endcase
                  end
               end
               bdu_pkg::OFF_FLAGS: begin
                  n.flags = pwdata_i[7:0];
               end
               bdu_pkg::OFF_SYSMODE: begin
                  n.sysmode[bdu_pkg::SYM_GIE] = pwdata_i[bdu_pkg::SYM_GIE];
               end
               bdu_pkg::OFF_MASK: begin
                  n.mask = pwdata_i[NUM_IRQ-1:0];
               end
               bdu_pkg::OFF_PEND: begin
                  n.pend = q.pend & ~pwdata_i[NUM_IRQ-1:0];
               end
               default: begin
                  n.op = q.op;  // status and service are read only
               end
            endcase
         end
      end
      // sequencer, an op result wins over a same-edge bus write
      case (q.state)
         bdu_pkg::ST_IDLE: begin
            // nothing to count; a start loads cnt in the bus write above,
            // so this branch must not touch cnt or the op runs one cycle
         end
         bdu_pkg::ST_EXEC: begin
            if (q.cnt != 4'h0) begin
               n.cnt = q.cnt - 4'h1;
            end else begin
               n.state = bdu_pkg::ST_IDLE;
               case (q.op)
                  bdu_pkg::OP_GLOBAL_IRQ_OFF: begin
                     n.sysmode[bdu_pkg::SYM_GIE] = 1'b0;
                     n.flags = q.flags;
                  end
                  bdu_pkg::OP_MINUS_ONE_WORD: begin
                     n.rf[even_a] = alu_c.res_word[15:8];
                     n.rf[odd_a]  = alu_c.res_word[7:0];
                     n.flags      = alu_c.flags_out;
                  end
                  default: begin
                     n.rf[q.addr] = alu_c.res_byte;
                     n.flags      = alu_c.flags_out;
                  end
               endcase
            end
         end
         default: begin
            n.state = bdu_pkg::ST_IDLE;
         end
      endcase
      // requests latch whatever the enable; a set beats a same-edge clear
      n.sync1 = irq_req_i;
      n.sync2 = q.sync1;
      n.pend  = n.pend | q.sync2;
      n.svc   = q.sysmode[bdu_pkg::SYM_GIE] ? (q.pend & q.mask) : '0;
   end

   // -------------------------------------------------------------
   // registers
   // -------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         q         <= '0;
         q.state   <= bdu_pkg::ST_IDLE;
         q.op      <= bdu_pkg::OP_BCD_FIXUP;
         q.flags   <= bdu_pkg::FLAGS_RST;
         q.sysmode <= bdu_pkg::SYSMODE_RST;
         q.mask    <= bdu_pkg::MASK_RST[NUM_IRQ-1:0];
      end else begin
         q <= n;
      end
   end

   // outputs straight from flops; busy_o decoded from the state
   assign prdata_o      = q.prdata;
   assign pready_o      = q.pready;
   assign pslverr_o     = q.pslverr;
   assign irq_service_o = q.svc;
   assign irq_enable_o  = q.sysmode[bdu_pkg::SYM_GIE];
   assign busy_o        = (q.state == bdu_pkg::ST_EXEC);

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   logic start_di;  // irq off accepted this edge
   assign start_di = commit & pwrite_i & (paddr_i == bdu_pkg::OFF_CTRL)
                     & (q.state == bdu_pkg::ST_IDLE) & (pwdata_i[1:0] == 2'h3);

   chk_irqoff_clears: assert property (fin && q.op == bdu_pkg::OP_GLOBAL_IRQ_OFF
      |=> !q.sysmode[bdu_pkg::SYM_GIE]) else $error("irq off left enable set");
   chk_irqoff_flags: assert property (fin && q.op == bdu_pkg::OP_GLOBAL_IRQ_OFF
      |=> q.flags == $past(q.flags)) else $error("irq off changed flags");
   chk_irqoff_len: assert property (start_di
      |=> (q.state == bdu_pkg::ST_EXEC) [*4] ##1 q.state == bdu_pkg::ST_IDLE)
      else $error("irq off did not take four cycles");
   chk_pend_latch: assert property ((|q.sync2)
      |=> (q.pend & $past(q.sync2)) == $past(q.sync2)) else $error("request lost");
   chk_svc_gated: assert property (!q.sysmode[bdu_pkg::SYM_GIE]
      |=> q.svc == '0) else $error("serviced while disabled");
   chk_dec_value: assert property (fin && q.op == bdu_pkg::OP_MINUS_ONE_BYTE
      |=> q.rf[$past(q.addr)] == $past(alu_c.byte_in) - 8'h01) else $error("bad decrement");
   chk_dec_keep: assert property (fin && q.op == bdu_pkg::OP_MINUS_ONE_BYTE
      |=> q.flags[7] == $past(q.flags[7]) && q.flags[3:2] == $past(q.flags[3:2]))
      else $error("decrement touched c, d or h");
   chk_da_addcarry: assert property (fin && q.op == bdu_pkg::OP_BCD_FIXUP
      && !q.flags[bdu_pkg::FLG_D] && alu_c.byte_in > 8'h99 |=> q.flags[bdu_pkg::FLG_C])
      else $error("fixup carry not set");
   chk_da_subcarry: assert property (fin && q.op == bdu_pkg::OP_BCD_FIXUP
      && q.flags[bdu_pkg::FLG_D] |=> q.flags[bdu_pkg::FLG_C] == $past(q.flags[bdu_pkg::FLG_C]))
      else $error("subtract fixup changed carry");
   chk_minus_one_word_op_borrow: assert property (fin && q.op == bdu_pkg::OP_MINUS_ONE_WORD
      && alu_c.word_in[7:0] == 8'h00
      |=> q.rf[$past(even_a)] == $past(alu_c.word_in[15:8]) - 8'h01)
      else $error("word borrow missing");
   chk_minus_one_word_op_zero: assert property (fin && q.op == bdu_pkg::OP_MINUS_ONE_WORD
      |=> q.flags[bdu_pkg::FLG_Z] == ($past(alu_c.word_in) == 16'h0001))
      else $error("word zero flag wrong");
   chk_da_zero: assert property (fin && q.op == bdu_pkg::OP_BCD_FIXUP
      |=> q.flags[bdu_pkg::FLG_Z] == (q.rf[$past(q.addr)] == 8'h00))
      else $error("fixup zero flag wrong");

   cov_da_sub: cover property (fin && q.op == bdu_pkg::OP_BCD_FIXUP && q.flags[bdu_pkg::FLG_D]);
   cov_minus_one_word_op_wrap: cover property (fin && q.op == bdu_pkg::OP_MINUS_ONE_WORD
      && alu_c.word_in[7:0] == 8'h00);
   cov_pend_off: cover property (!q.sysmode[bdu_pkg::SYM_GIE] && (|q.sync2));
endmodule

// File: shared/bdu_alu_if.sv
// carrier between the sequencer and the arithmetic unit
`timescale 1ns/1ns
interface bdu_alu_if;
   bdu_pkg::bdu_op_type op;        // operation in progress
   logic [7:0]          flags_in;  // flags before the op
   logic [7:0]          byte_in;   // destination byte
   logic [15:0]         word_in;   // destination word, even byte high
   logic [7:0]          res_byte;  // byte result
   logic [15:0]         res_word;  // word result
   logic [7:0]          flags_out; // flags after the op
   modport seq (output op, flags_in, byte_in, word_in, input res_byte, res_word, flags_out);
   modport alu (input op, flags_in, byte_in, word_in, output res_byte, res_word, flags_out);
endinterface

// File: shared/bdu_pkg.sv
// constants and types for the bcd adjust and decrement unit
package bdu_pkg;
   // -------------------------------------------------------------
   // register byte offsets on the apb bus
   // -------------------------------------------------------------
   localparam logic [11:0] OFF_CTRL    = 12'h000;  // op start (write), last op (read)
   localparam logic [11:0] OFF_STATUS  = 12'h004;  // busy and address in use
   localparam logic [11:0] OFF_FLAGS   = 12'h008;  // condition flags
   localparam logic [11:0] OFF_SYSMODE = 12'h00C;  // system_mode_reg
   localparam logic [11:0] OFF_MASK    = 12'h010;  // irq_mask_reg
   localparam logic [11:0] OFF_PEND    = 12'h014;  // pending bits, write one to clear
   localparam logic [11:0] OFF_SVC     = 12'h018;  // requests the cpu may service
   localparam logic [1:0]  RF_SEL      = 2'h1;     // paddr[7:6] of the operand file
   // -------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------
   localparam int FLG_C   = 7;   // carry
   localparam int FLG_Z   = 6;   // zero
   localparam int FLG_S   = 5;   // sign
   localparam int FLG_V   = 4;   // overflow
   localparam int FLG_D   = 3;   // decimal: last op was a subtract
   localparam int FLG_H   = 2;   // half carry
   localparam int SYM_GIE = 0;   // global_irq_enable_bit
   localparam int CTL_IND = 2;   // ctrl: indirect destination
   localparam int CTL_IDX = 4;   // ctrl: low bit of register index
   // -------------------------------------------------------------
   // reset values and cycle counts
   // -------------------------------------------------------------
   localparam logic [7:0] FLAGS_RST   = 8'h00;
   localparam logic [7:0] SYSMODE_RST = 8'h00;
   localparam logic [7:0] MASK_RST    = 8'h00;
   localparam logic [3:0] CYC_BYTE    = 4'h4;  // bcd fixup and byte decrement
   localparam logic [3:0] CYC_WORD    = 4'h8;  // word decrement
   localparam logic [3:0] CYC_IRQOFF  = 4'h4;  // global_irq_off_op
   // -------------------------------------------------------------
   // operations and states
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      OP_BCD_FIXUP = 2'h0,
      OP_MINUS_ONE_BYTE = 2'h1,
      OP_MINUS_ONE_WORD = 2'h2,
      OP_GLOBAL_IRQ_OFF = 2'h3
   } bdu_op_type;
   typedef enum logic [1:0] {
      ST_IDLE = 2'h1,
      ST_EXEC = 2'h2
   } bdu_state_type;
endpackage

// File: tb/bcd_adjust_decrement_unit_test.sv
// self-checking bench for the bcd adjust and decrement unit
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
   $display("Error %0t got %h exp %h", $time, (a), (b)); end end
module bcd_adjust_decrement_unit_test;
   // ---------------------------------------------------------
   // stimulus and design outputs
   // ---------------------------------------------------------
   logic        clk_i     = 1'b0;
   logic        rst_i     = 1'b1;
   logic [11:0] paddr_i   = 12'h000;
   logic        psel_i    = 1'b0;
   logic        penable_i = 1'b0;
   logic        pwrite_i  = 1'b0;
   logic [31:0] pwdata_i  = 32'h0;
   logic [7:0]  irq_req_i = 8'h00;
   logic [31:0] prdata_o;
   logic        pready_o;
   logic        pslverr_o;
   logic [7:0]  irq_service_o;
   logic        irq_enable_o;
   logic        busy_o;
   int          n_fail    = 0;   // mismatches
   int          n_tests   = 0;   // comparisons
   // op table: ctrl byte, flags in, target, value, result, flags out
   logic [7:0]  ctl [0:12] = '{8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10,
                               8'h10, 8'h21, 8'h35, 8'h21, 8'h42, 8'h66};
   logic [7:0]  fin [0:12] = '{8'h00, 8'h00, 8'h04, 8'h80, 8'h0C, 8'h88, 8'h8C,
                               8'h00, 8'h8C, 8'h8C, 8'h8C, 8'h8C, 8'h8C};
   logic [3:0]  tgt [0:12] = '{4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1,
                               4'h1, 4'h2, 4'h2, 4'h2, 4'h4, 4'h4};
   logic [15:0] val [0:12] = '{16'h3C, 16'h9A, 16'h32, 16'h15, 16'h0F, 16'h90,
                               16'h7F, 16'h85, 16'h80, 16'h80, 16'h01, 16'h8000,
                               16'h0001};
   logic [15:0] res [0:12] = '{16'h42, 16'h00, 16'h38, 16'h75, 16'h09, 16'h30,
                               16'h19, 16'h85, 16'h7F, 16'h7F, 16'h00, 16'h7FFF,
                               16'h0000};
   logic [7:0]  fex [0:12] = '{8'h00, 8'hC0, 8'h04, 8'h80, 8'h0C, 8'h88, 8'h8C,
                               8'h20, 8'h9C, 8'h9C, 8'hCC, 8'h9C, 8'hCC};
   logic [31:0] rdat;        // read data of a raw transfer
   logic        rerr;        // error flag of a raw transfer
   int          ncyc;        // measured busy length
   always #2 clk_i = ~clk_i;
   bdu_top dut_u (
      .clk_i         (clk_i),
      .rst_i         (rst_i),
      .paddr_i       (paddr_i),
      .psel_i        (psel_i),
      .penable_i     (penable_i),
      .pwrite_i      (pwrite_i),
      .pwdata_i      (pwdata_i),
      .prdata_o      (prdata_o),
      .pready_o      (pready_o),
      .pslverr_o     (pslverr_o),
      .irq_req_i     (irq_req_i),
      .irq_service_o (irq_service_o),
      .irq_enable_o  (irq_enable_o),
      .busy_o        (busy_o)
   );
   // ---------------------------------------------------------
   // apb master: request held until pready is sampled high
   // ---------------------------------------------------------
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      @(posedge clk_i);
      psel_i    <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i  <= w;
      paddr_i   <= a;
      pwdata_i  <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      // slave sets the pace; only the watchdog ends a hang
      do begin
         @(posedge clk_i);
      end while (pready_o !== 1'b1);
      r = prdata_o;
      e = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      xfer(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic        e;
      xfer(1'b0, a, 32'h0, r, e);
      `CHK(r, x)
      `CHK(e, 1'b0)
   endtask
   // start an op and count the cycles busy stays high
   task automatic op(input logic [7:0] c, output int n);
      int k;
      k = 0;
      n = 0;
      wr(bdu_pkg::OFF_CTRL, {24'h0, c});
      do begin
         @(posedge clk_i);
         k++;
      end while (busy_o !== 1'b1 && k < 8);
      do begin
         @(posedge clk_i);
         n++;
      end while (busy_o === 1'b1 && n < 40);
   endtask
   function automatic logic [11:0] opnd(input logic [3:0] i);
      return 12'h040 + {6'h0, i, 2'h0};
   endfunction
   // ---------------------------------------------------------
   // verdict: the one place the run ends
   // ---------------------------------------------------------
   task automatic close_out;
      if (n_fail == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // watchdog: the sequence needs well under 3000 cycles
   initial begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      close_out();
   end
   // ---------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(bdu_pkg::OFF_FLAGS, 32'h0);
      rd(bdu_pkg::OFF_SYSMODE, 32'h0);
      rd(bdu_pkg::OFF_MASK, 32'h0);
      // pointers for the indirect rows: r3 -> 2, r6 -> 4
      wr(opnd(4'h3), 32'h02);
      wr(opnd(4'h6), 32'h04);
      for (int i = 0; i < 13; i++) begin
         wr(bdu_pkg::OFF_FLAGS, {24'h0, fin[i]});
         if (ctl[i][1:0] == 2'h2) begin
            wr(opnd(tgt[i]), {24'h0, val[i][15:8]});
            wr(opnd(tgt[i] + 4'h1), {24'h0, val[i][7:0]});
         end else begin
            wr(opnd(tgt[i]), {24'h0, val[i][7:0]});
         end
         op(ctl[i], ncyc);
         if (ctl[i][1:0] == 2'h2) begin
            `CHK(4'(ncyc), bdu_pkg::CYC_WORD)
            rd(opnd(tgt[i]), {24'h0, res[i][15:8]});
            rd(opnd(tgt[i] + 4'h1), {24'h0, res[i][7:0]});
         end else begin
            `CHK(4'(ncyc), bdu_pkg::CYC_BYTE)
            rd(opnd(tgt[i]), {24'h0, res[i][7:0]});
         end
         rd(bdu_pkg::OFF_FLAGS, {24'h0, fex[i]});
      end
      // last row went through pointer r6, so the resolved address is 4
      rd(bdu_pkg::OFF_STATUS, 32'h40);
      // unmapped place answers with an error and zero data
      xfer(1'b0, 12'h020, 32'h0, rdat, rerr);
      `CHK(rerr, 1'b1)
      `CHK(rdat, 32'h0)
      // enable, then a request is serviced
      wr(bdu_pkg::OFF_MASK, 32'h03);
      wr(bdu_pkg::OFF_SYSMODE, 32'h01);
      irq_req_i <= 8'h01;
      repeat (5) @(posedge clk_i);
      `CHK(irq_enable_o, 1'b1)
      `CHK(irq_service_o, 8'h01)
      // global off keeps flags and takes four cycles
      wr(bdu_pkg::OFF_FLAGS, 32'hAC);
      op(8'h03, ncyc);
      `CHK(4'(ncyc), bdu_pkg::CYC_IRQOFF)
      rd(bdu_pkg::OFF_SYSMODE, 32'h0);
      rd(bdu_pkg::OFF_FLAGS, 32'hAC);
      rd(bdu_pkg::OFF_CTRL, 32'h3);
      `CHK(irq_enable_o, 1'b0)
      // a new request still latches but is not serviced
      irq_req_i <= 8'h02;
      repeat (5) @(posedge clk_i);
      rd(bdu_pkg::OFF_PEND, 32'h03);
      rd(bdu_pkg::OFF_SVC, 32'h0);
      `CHK(irq_service_o, 8'h00)
      // clear both while disabled; line 1 is still high and sets again
      wr(bdu_pkg::OFF_PEND, 32'h03);
      rd(bdu_pkg::OFF_PEND, 32'h02);
      close_out();
   end
endmodule
